// >>> pbgci_pkg.sv
// constants shared by the port b gpio change interrupt block
package pbgci_pkg;
	// register index width; byte address is four times the index
	localparam int IDX_W = 9;
	localparam logic [IDX_W-1:0] IDX_PORT_DATA = 9'h006;
	localparam logic [IDX_W-1:0] IDX_OPTION = 9'h081;
	localparam logic [IDX_W-1:0] IDX_DIRECTION = 9'h086;
	localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL_REG = 9'h00b;
	localparam logic [IDX_W-1:0] IDX_BIT_SET = 9'h00c;
	localparam logic [IDX_W-1:0] IDX_BIT_CLR = 9'h00d;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 9'h00e;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 9'h00f;
	// index bit that selects the mirrored bank
	localparam int MIRROR_BIT = 8;

	// values after reset
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] DIRECTION_RST = 8'hff;
	localparam logic [7:0] INTERRUPT_CONTROL_REG_RST = 8'h00;
	localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;
	localparam logic [7:0] REFERENCE_RST = 8'h00;

	// field positions
	localparam int PULLUP_N_BIT = 7;
	localparam int CHANGE_FLAG_BIT = 0;
	localparam int CHANGE_EN_BIT = 3;
	localparam int CHANGE_LO = 4;
	localparam int CHANGE_HI = 7;
	localparam int PROG_PIN_BIT = 4;
	localparam int STAT_CHANGE_BIT = 0;
	localparam logic [3:0] UPPER_ALL_IN = 4'hf;
endpackage

// >>> pbgci_top.sv
// port b gpio with pull-ups, change interrupt and apb register slave
// How it works
// direction bit one tri-states the pin driver, pin becomes input.
// direction bit zero drives the pin from its output latch.
// an enabled alternate function may override pin direction.
// port reads return sampled pin levels; writes update the latch.
// bit set and clear writes merge new bits into sampled pin levels, then store latch.
// option bit seven, active low, enables all weak pull-ups.
// pull-up is forced off on any pin configured as output.
// option resets to all ones, so pull-ups start disabled.
// only upper four input pins take part in change detection.
// upper inputs compared with reference taken at last port access.
// mismatches are ored into change flag, interrupt control bit zero.
// a set change flag can wake the device from sleep.
// any port read or write reloads the reference, ending mismatch.
// mismatch keeps setting the flag; handler reads port, then clears.
// a change landing on a port read edge may be missed.
// software should not poll the port while using change interrupts.
// low voltage programming fuse disables pin four change and pull-up.
// direction resets to all inputs; data latch keeps its value.
// registers answer identically at both mirrored bank addresses.
`timescale 1ns/1ps
module pbgci_top import pbgci_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int PINS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pullup_on,
	input wire logic [PINS-1:0] alt_enable,
	input wire logic [PINS-1:0] alt_oe,
	input wire logic [PINS-1:0] alt_out,
	input wire logic low_volt_prog_fuse,
	output logic low_volt_prog_pin,
	output logic wake_request,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [PINS-1:0] pin_meta_reg;
	logic [PINS-1:0] pin_sync_reg;
	logic fuse_meta_reg;
	logic fuse_sync_reg;
	logic [PINS-1:0] latch_reg;
	logic [PINS-1:0] latch_next;
	logic [PINS-1:0] direction_reg;
	logic [7:0] option_reg;
	logic [7:0] interrupt_control_reg_reg;
	logic [7:0] irq_status_reg;
	logic [7:0] irq_mask_reg;
	logic [PINS-1:0] reference_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [PINS-1:0] dir_eff;
	logic [3:0] mismatch;
	logic any_mismatch;
	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic port_touch;
	logic [PINS-1:0] prog_mask;

	// strips the mirror bit so both banks land on one register
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
		logic [IDX_W-1:0] i;
		i = a[IDX_W+1:2];
		i[MIRROR_BIT] = 1'b0;
		return i == idx;
	endfunction

	// known register test, used only for the slave error
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return hit(a, IDX_PORT_DATA) | hit(a, IDX_OPTION) | hit(a, IDX_DIRECTION)
			| hit(a, IDX_INTERRUPT_CONTROL_REG) | hit(a, IDX_BIT_SET) | hit(a, IDX_BIT_CLR)
			| hit(a, IDX_IRQ_STATUS) | hit(a, IDX_IRQ_MASK);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin and fuse synchronisers; nothing reads the first stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			fuse_meta_reg <= 1'b0;
			fuse_sync_reg <= 1'b0;
		end else begin
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
			fuse_meta_reg <= low_volt_prog_fuse;
			fuse_sync_reg <= fuse_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb phase decode; every access completes without wait states
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr = access & pwrite;
	assign rd = access & ~pwrite;
	assign pready = access;
	assign port_touch = access & (hit(paddr, IDX_PORT_DATA) | hit(paddr, IDX_BIT_SET)
		| hit(paddr, IDX_BIT_CLR));

	// read data captured in setup so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			pslverr_reg <= ~mapped(paddr);
			prdata_reg <= '0;
			if (hit(paddr, IDX_PORT_DATA))
				prdata_reg[PINS-1:0] <= pin_sync_reg;
			if (hit(paddr, IDX_OPTION))
				prdata_reg[7:0] <= option_reg;
			if (hit(paddr, IDX_DIRECTION))
				prdata_reg[PINS-1:0] <= direction_reg;
			if (hit(paddr, IDX_INTERRUPT_CONTROL_REG))
				prdata_reg[7:0] <= interrupt_control_reg_reg;
			if (hit(paddr, IDX_IRQ_STATUS))
				prdata_reg[7:0] <= irq_status_reg;
			if (hit(paddr, IDX_IRQ_MASK))
				prdata_reg[7:0] <= irq_mask_reg;
		end
	end
	assign prdata = prdata_reg;
	assign pslverr = access & pslverr_reg;

	////////////////////////////////////////////////////////////////////////
	// output latch: bit set and clear merge into sampled pins, so input bits pick up pin levels
	always_comb begin
		latch_next = latch_reg;
		if (wr && hit(paddr, IDX_PORT_DATA))
			latch_next = pwdata[PINS-1:0];
		else if (wr && hit(paddr, IDX_BIT_SET))
			latch_next = pin_sync_reg | pwdata[PINS-1:0];
		else if (wr && hit(paddr, IDX_BIT_CLR))
			latch_next = pin_sync_reg & ~pwdata[PINS-1:0];
	end

	// no reset: content survives resets, unknown after power-up
	always_ff @(posedge pclk) begin
		latch_reg <= latch_next;
	end

	////////////////////////////////////////////////////////////////////////
	// direction and option registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			direction_reg <= DIRECTION_RST;
			option_reg <= OPTION_RST;
		end else begin
			if (wr && hit(paddr, IDX_DIRECTION))
				direction_reg <= pwdata[PINS-1:0];
			if (wr && hit(paddr, IDX_OPTION))
				option_reg <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers; alternate functions take over direction and data
	assign prog_mask = fuse_sync_reg ? (PINS'(1) << PROG_PIN_BIT) : '0;
	assign low_volt_prog_pin = fuse_sync_reg & pin_sync_reg[PROG_PIN_BIT];
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			assign dir_eff[g] = alt_enable[g] ? ~alt_oe[g] : direction_reg[g];
			assign pin_oe[g] = ~dir_eff[g];
			// gated by direction so an unknown latch stays off pin_out on input pins
			assign pin_out[g] = alt_enable[g] ? (alt_out[g] & alt_oe[g])
				: (latch_reg[g] & ~direction_reg[g]);
			// pull-up only on inputs, global active-low enable
			assign pullup_on[g] = ~option_reg[PULLUP_N_BIT] & dir_eff[g]
				& ~prog_mask[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// change comparison on upper inputs against the last sampled reference
	assign mismatch = (pin_sync_reg[CHANGE_HI:CHANGE_LO] ^ reference_reg[CHANGE_HI:CHANGE_LO])
		& dir_eff[CHANGE_HI:CHANGE_LO]
		& ~prog_mask[CHANGE_HI:CHANGE_LO];
	assign any_mismatch = |mismatch;

	// reference reloads on every port access; a change in that same edge
	// is absorbed and not flagged, which is accepted behaviour
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			reference_reg <= REFERENCE_RST;
		else if (port_touch)
			reference_reg <= pin_sync_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt control: flag set by mismatch wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_control_reg_reg <= INTERRUPT_CONTROL_REG_RST;
		end else begin
			if (wr && hit(paddr, IDX_INTERRUPT_CONTROL_REG))
				interrupt_control_reg_reg <= pwdata[7:0];
			if (any_mismatch && !port_touch)
				interrupt_control_reg_reg[CHANGE_FLAG_BIT] <= 1'b1;
		end
	end
	// the handler must read the port before clearing, or the flag returns
	assign wake_request = interrupt_control_reg_reg[CHANGE_FLAG_BIT] & interrupt_control_reg_reg[CHANGE_EN_BIT];

	// sticky status, cleared by reading it; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_reg <= IRQ_STATUS_RST;
			irq_mask_reg <= IRQ_MASK_RST;
		end else begin
			if (rd && hit(paddr, IDX_IRQ_STATUS))
				irq_status_reg <= '0;
			if (any_mismatch && !port_touch)
				irq_status_reg[STAT_CHANGE_BIT] <= 1'b1;
			if (wr && hit(paddr, IDX_IRQ_MASK))
				irq_mask_reg <= pwdata[7:0];
		end
	end
	assign irq = |(irq_status_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_quiet_change;
		!psel ##1 (any_mismatch && !port_touch);
	endsequence

	sequence s_port_read;
		setup && !pwrite && hit(paddr, IDX_PORT_DATA);
	endsequence

	property p_input_tristate;
		@(posedge pclk) disable iff (!presetn)
		((pin_oe & direction_reg & ~alt_enable) == '0);
	endproperty
	a_input_tristate: assert property (p_input_tristate) else $error("input pin driven");

	property p_output_from_latch;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, IDX_PORT_DATA) && alt_enable == '0) |=>
		((pin_out & ~direction_reg) == ($past(pwdata[PINS-1:0]) & ~direction_reg));
	endproperty
	a_output_from_latch: assert property (p_output_from_latch) else $error("pin not latch");

	property p_alt_override;
		@(posedge pclk) disable iff (!presetn)
		((alt_enable & (pin_oe ^ alt_oe)) == '0);
	endproperty
	a_alt_override: assert property (p_alt_override) else $error("alt direction lost");

	property p_read_pins;
		@(posedge pclk) disable iff (!presetn)
		s_port_read |=> (prdata[PINS-1:0] == $past(pin_sync_reg)) && prdata[31:PINS] == '0;
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("port read not pins");

	property p_bit_set_merge;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, IDX_BIT_SET)) |=>
		(latch_reg == ($past(pin_sync_reg) | $past(pwdata[PINS-1:0])));
	endproperty
	a_bit_set_merge: assert property (p_bit_set_merge) else $error("merge wrong");

	property p_pullup_off;
		@(posedge pclk) disable iff (!presetn)
		(option_reg[PULLUP_N_BIT] || (pullup_on & ~dir_eff) != '0) |-> (pullup_on & ~dir_eff) == '0
		&& (!option_reg[PULLUP_N_BIT] || pullup_on == '0);
	endproperty
	a_pullup_off: assert property (p_pullup_off) else $error("pull-up wrongly on");

	property p_flag_sets;
		@(posedge pclk) disable iff (!presetn)
		s_quiet_change |=> interrupt_control_reg_reg[CHANGE_FLAG_BIT] ##0 irq_status_reg[STAT_CHANGE_BIT];
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("change not flagged");

	property p_output_excluded;
		@(posedge pclk) disable iff (!presetn)
		(dir_eff[CHANGE_HI:CHANGE_LO] != UPPER_ALL_IN) |->
		((mismatch & ~dir_eff[CHANGE_HI:CHANGE_LO]) == '0);
	endproperty
	a_output_excluded: assert property (p_output_excluded) else $error("output compared");

	property p_reference_reload;
		@(posedge pclk) disable iff (!presetn)
		port_touch |=> reference_reg == $past(pin_sync_reg);
	endproperty
	a_reference_reload: assert property (p_reference_reload) else $error("reference stale");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		(interrupt_control_reg_reg[CHANGE_EN_BIT] && $rose(interrupt_control_reg_reg[CHANGE_FLAG_BIT])) |-> wake_request;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on change");

	property p_prog_pin;
		@(posedge pclk) disable iff (!presetn)
		fuse_sync_reg |-> !pullup_on[PROG_PIN_BIT] && !mismatch[PROG_PIN_BIT - CHANGE_LO];
	endproperty
	a_prog_pin: assert property (p_prog_pin) else $error("program pin active");

	// bit clear merges into sampled pins just like bit set
	property p_bit_clr_merge;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, IDX_BIT_CLR)) |=>
		(latch_reg == ($past(pin_sync_reg) & ~$past(pwdata[PINS-1:0])));
	endproperty
	a_bit_clr_merge: assert property (p_bit_clr_merge) else $error("clear merge wrong");

	// a port access cycle absorbs the change, so the flag cannot rise there
	property p_touch_absorbs;
		@(posedge pclk) disable iff (!presetn)
		(port_touch && !interrupt_control_reg_reg[CHANGE_FLAG_BIT]) |=> !interrupt_control_reg_reg[CHANGE_FLAG_BIT];
	endproperty
	a_touch_absorbs: assert property (p_touch_absorbs) else $error("flag set on access");

	property p_status_read_clears;
		@(posedge pclk) disable iff (!presetn)
		(rd && hit(paddr, IDX_IRQ_STATUS) && !any_mismatch) |=> irq_status_reg == '0;
	endproperty
	a_status_read_clears: assert property (p_status_read_clears) else $error("status kept");

	property p_output_no_pullup;
		@(posedge pclk) disable iff (!presetn)
		((pullup_on & pin_oe) == '0);
	endproperty
	a_output_no_pullup: assert property (p_output_no_pullup) else $error("pull-up on output");

endmodule

// >>> pbgci_pads.sv
// far-side pad model: keypad lines, pull-ups and chip drivers on one wire
`timescale 1ns/1ps
module pbgci_pads (
	input wire logic pclk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pullup_on,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pad
);
	logic float_reg = 1'b0;
	// a line nobody holds wanders, so nothing may lean on a floating value
	always_ff @(posedge pclk) begin
		float_reg <= ~float_reg;
	end
	// chip driver wins, keypad only drives lines the chip leaves alone
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pad[i] = pin_out[i];
			else if (ext_en[i])
				pad[i] = ext_val[i];
			else if (pullup_on[i])
				pad[i] = 1'b1;
			else
				pad[i] = float_reg;
		end
	end
endmodule

// >>> tb_top.sv
// self-checking bench for the port b gpio block
`timescale 1ns/1ps
module tb_top import pbgci_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fuse = 0, slv, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, seed = 32'he868_1d1b;
	logic [7:0] pad, pin_out, pin_oe, pullup_on, r, dir, ev, e;
	logic [7:0] alt_enable = '0, alt_oe = '0, alt_out = '0, ext_val = '0, ext_en = 8'hff;
	logic wake_request, irq, prog_pin;
	int err_count = 0, n_tests = 0, cycles = 0;

	pbgci_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pad), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_on(pullup_on), .alt_enable(alt_enable), .alt_oe(alt_oe), .alt_out(alt_out),
		.low_volt_prog_fuse(fuse), .low_volt_prog_pin(prog_pin), .wake_request(wake_request),
		.irq(irq));
	pbgci_pads i_pads (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
		.ext_en(ext_en), .ext_val(ext_val), .pad(pad));

	// xorshift keeps the random stream repeatable
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	// pad level the port should see: latch on outputs, far side on inputs
	function automatic logic [7:0] pad_exp(input logic [7:0] lat, input logic [7:0] d,
		input logic [7:0] far);
		return (lat & ~d) | (far & d);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer, request held until pready is seen high
	task automatic apb(input logic [8:0] idx, input logic wr, input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {1'b0, idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16)
			err_count++;
	endtask
	task automatic wr(input logic [8:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d);
	endtask
	task automatic rdc(input logic [8:0] idx, input logic [7:0] exp);
		apb(idx, 1'b0, 8'h00);
		chk(rd, {24'h00_0000, exp});
	endtask
	task automatic results();
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		forever #4 pclk = ~pclk;
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk(pin_oe, 0);
		chk(pullup_on, 0);
		rdc(IDX_OPTION, OPTION_RST);
		rdc(IDX_DIRECTION, DIRECTION_RST);
		rdc(9'h010, 8'h00);
		chk(slv, 1); // unmapped index refused
		// random latch, direction and keypad levels, direction via mirror bank
		for (int k = 0; k < 8; k++) begin
			r = rnd();
			dir = rnd();
			ev = rnd();
			wr(IDX_PORT_DATA, r);
			ext_val <= ev;
			wr(IDX_DIRECTION | 9'h100, dir);
			repeat (4) @(posedge pclk);
			e = ~dir;
			chk(pin_oe, e);
			e = r & ~dir;
			chk(pin_out, e);
			rdc(IDX_PORT_DATA, pad_exp(r, dir, ev));
			rdc(IDX_DIRECTION, dir);
		end
		wr(IDX_OPTION, 8'h7f);
		@(posedge pclk);
		chk(pullup_on, dir);
		// keypad released: inputs must rise on the pull-ups alone
		ext_en <= 8'h00;
		repeat (4) @(posedge pclk);
		rdc(IDX_PORT_DATA, pad_exp(r, dir, 8'hff));
		ext_en <= 8'hff;
		fuse <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(pullup_on, dir & 8'hef);
		e = pad_exp(r, dir, ev);
		chk(prog_pin, e[4]);
		fuse <= 1'b0;
		wr(IDX_OPTION, 8'hff);
		@(posedge pclk);
		chk(pullup_on, 0);
		chk(prog_pin, 0);
		// bit set copies input pin levels into the latch
		wr(IDX_DIRECTION, 8'hf0);
		wr(IDX_PORT_DATA, 8'h00);
		ext_val <= 8'ha0;
		repeat (4) @(posedge pclk);
		wr(IDX_BIT_SET, 8'h01);
		wr(IDX_DIRECTION, 8'h00);
		@(posedge pclk);
		chk(pin_out, 8'ha1);
		wr(IDX_BIT_CLR, 8'h80);
		@(posedge pclk);
		chk(pin_out, 8'h21);
		// change interrupt: arm, trip, clear in the right order
		wr(IDX_DIRECTION, 8'hf0);
		wr(IDX_IRQ_MASK, 8'h01);
		repeat (4) @(posedge pclk);
		rdc(IDX_PORT_DATA, 8'ha1);
		wr(IDX_INTERRUPT_CONTROL_REG, 8'h08);
		apb(IDX_IRQ_STATUS, 1'b0, 8'h00);
		repeat (4) @(posedge pclk);
		chk(irq, 0);
		ext_val <= 8'h20;
		repeat (6) @(posedge pclk); // no polling while waiting
		chk(irq, 1);
		chk(wake_request, 1);
		rdc(IDX_INTERRUPT_CONTROL_REG, 8'h09);
		wr(IDX_INTERRUPT_CONTROL_REG, 8'h08);
		repeat (3) @(posedge pclk);
		rdc(IDX_INTERRUPT_CONTROL_REG, 8'h09);
		rdc(IDX_PORT_DATA, 8'h21);
		wr(IDX_INTERRUPT_CONTROL_REG, 8'h08);
		repeat (4) @(posedge pclk);
		rdc(IDX_INTERRUPT_CONTROL_REG, 8'h08);
		rdc(IDX_IRQ_STATUS, 8'h01);
		@(posedge pclk);
		chk(irq, 0);
		// an upper pin turned output must not trip the comparison
		wr(IDX_PORT_DATA, 8'h00);
		ext_val <= 8'ha0;
		repeat (4) @(posedge pclk);
		rdc(IDX_PORT_DATA, 8'ha0);
		wr(IDX_INTERRUPT_CONTROL_REG, 8'h08);
		wr(IDX_DIRECTION, 8'h7f);
		repeat (6) @(posedge pclk);
		rdc(IDX_INTERRUPT_CONTROL_REG, 8'h08);
		// alternate function takes over its pins
		r = rnd();
		alt_enable <= r;
		alt_oe <= 8'hff;
		alt_out <= 8'h55;
		repeat (2) @(posedge pclk);
		chk(pin_oe, r | 8'h80);
		chk(pin_out, r & 8'h55);
		alt_enable <= 8'h00;
		// mid-run reset keeps the latch, restores all inputs
		wr(IDX_PORT_DATA, 8'h5a);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(IDX_DIRECTION, 8'hff);
		wr(IDX_DIRECTION, 8'h00);
		@(posedge pclk);
		chk(pin_out, 8'h5a);
		results();
	end
endmodule
